// [common/cmp_ctrl_pkg.sv]
// Operation
// [R1] Analog circuit powered only while enable set
// [R2] Output enable drives result onto pin
// [R3] Invert bit inverts comparator result
// [R4] Mode bit: one amplifier, zero comparator
// [R5] Matching event sets flag, blocks retriggers
// [R6] Result bit shows input compare, inverted option
// [R7] Writable bits reset zero, unused read zero
// [R8] Amplifier mode keeps result off pin
// [R9] Writing zero clears flag and rearms
package cmp_ctrl_pkg;
   // Register map (byte addresses)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
   // Control field positions
   localparam int BIT_ON = 15;
   localparam int BIT_PIN = 14;
   localparam int BIT_INV = 13;
   localparam int BIT_AMP = 10;
   localparam int BIT_TRIP = 9;
   localparam int BIT_RES = 8;
   localparam int BIT_EDGE_HI = 7;
   localparam int BIT_EDGE_LO = 6;
   localparam int BIT_REF = 4;
   localparam int BIT_CH_HI = 1;
   localparam int BIT_CH_LO = 0;
   // Bits software may write and reset value
   localparam logic [15:0] CTRL_WMASK = 16'hE4D3;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   // Event polarity encodings
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // Bus slave states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_t;
endpackage

// [hdl/comparator_control.sv]
`timescale 1ns/100ps
module comparator_control (
   // Clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Analog front end
   input  wire logic        cmp_raw_i,
   output logic             analog_block_on_o,
   output logic             amplifier_select_o,
   output logic             ref_select_o,
   output logic [1:0]       input_select_o,
   // Pin and interrupt
   output logic             compare_result_pin_o,
   output logic             compare_result_pin_oe_n_o,
   output logic             irq_o
);
   import cmp_ctrl_pkg::*;

   bus_state_t  bus_q;
   logic [15:0] ctrl_q;
   logic        trip_q;
   logic        stat_q;
   logic        mask_q;
   logic        sync1_q;
   logic        sync2_q;
   logic        result_q;
   logic        pin_q;
   logic        pin_en_q;
   logic        hit;
   logic        trip_evt;
   logic        req;
   logic        wr;
   logic        lo_lane;
   logic        hi_lane;
   logic [15:0] ctrl_rd;

   // Bus decode
   assign req = cyc_i & stb_i & (bus_q == BUS_IDLE);
   assign wr = req & we_i;
   assign lo_lane = sel_i[0];
   assign hi_lane = sel_i[1];
   assign ack_o = (bus_q == BUS_ACK);

   // Bus state: one wait state, then ack for a cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_q <= BUS_IDLE;
      end else if (ce_i) begin
         case (bus_q)
            BUS_IDLE: if (req) bus_q <= BUS_ACK;
            BUS_ACK:  bus_q <= BUS_IDLE;
            default:  bus_q <= BUS_IDLE;
         endcase
      end
   end

   // Pin synchroniser for comparator output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else if (ce_i) begin
         sync1_q <= cmp_raw_i;
         sync2_q <= sync1_q;
      end
   end

   // Polarity applied, gated by enable and comparator mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_q <= 1'b0;
      end else if (ce_i) begin
         result_q <= ctrl_q[BIT_ON] & ~ctrl_q[BIT_AMP] & (sync2_q ^ ctrl_q[BIT_INV]); // see [R3] see [R6]
      end
   end

   // Writable control fields
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RST; // see [R7]
      end else if (ce_i && wr && adr_i == ADDR_CTRL) begin
         if (lo_lane) ctrl_q[7:0] <= dat_i[7:0] & CTRL_WMASK[7:0];
         if (hi_lane) ctrl_q[15:8] <= dat_i[15:8] & CTRL_WMASK[15:8];
      end
   end

   edge_detect edge_detect_i (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .level_i(result_q),
      .sel_i  (ctrl_q[BIT_EDGE_HI:BIT_EDGE_LO]),
      .hit_o  (hit)
   );

   // A new trip only while armed
   assign trip_evt = hit & ~trip_q; // see [R5]

   // Trip flag: set wins over a clearing write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trip_q <= 1'b0;
      end else if (ce_i) begin
         if (trip_evt) begin
            trip_q <= 1'b1; // see [R5]
         end else if (wr && adr_i == ADDR_CTRL && hi_lane && !dat_i[BIT_TRIP]) begin
            trip_q <= 1'b0; // see [R9]
         end
      end
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= 1'b0;
      end else if (ce_i) begin
         if (trip_evt) begin
            stat_q <= 1'b1;
         end else if (wr && adr_i == ADDR_IRQ_STAT && lo_lane && dat_i[0]) begin
            stat_q <= 1'b0;
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= 1'b0;
      end else if (ce_i && wr && adr_i == ADDR_IRQ_MASK && lo_lane) begin
         mask_q <= dat_i[0];
      end
   end

   assign irq_o = stat_q & mask_q;

   // Pin drive, off in amplifier mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_q <= 1'b0;
         pin_en_q <= 1'b0;
      end else if (ce_i) begin
         pin_q <= result_q;
         pin_en_q <= ctrl_q[BIT_ON] & ctrl_q[BIT_PIN] & ~ctrl_q[BIT_AMP]; // see [R2] see [R8]
      end
   end

   assign compare_result_pin_o = pin_q & pin_en_q;
   assign compare_result_pin_oe_n_o = ~pin_en_q;

   // Analog controls
   assign analog_block_on_o = ctrl_q[BIT_ON]; // see [R1]
   assign amplifier_select_o = ctrl_q[BIT_AMP]; // see [R4]
   assign ref_select_o = ctrl_q[BIT_REF];
   assign input_select_o = ctrl_q[BIT_CH_HI:BIT_CH_LO];

   // Readback view, unused bits zero
   always_comb begin
      ctrl_rd = ctrl_q; // see [R7]
      ctrl_rd[BIT_TRIP] = trip_q;
      ctrl_rd[BIT_RES] = result_q;
   end

   // Read data register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= WORD_ZERO;
      end else if (ce_i && req) begin
         if (adr_i == ADDR_CTRL) begin
            dat_o <= {16'h0000, ctrl_rd};
         end else if (adr_i == ADDR_IRQ_STAT) begin
            dat_o <= {31'h0000_0000, stat_q};
         end else if (adr_i == ADDR_IRQ_MASK) begin
            dat_o <= {31'h0000_0000, mask_q};
         end else begin
            dat_o <= WORD_ZERO;
         end
      end
   end

   // Checks on pin drive and mode

   // Pin released in amplifier mode
   AST_PIN_OFF_AMP: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && ctrl_q[BIT_AMP] |=> compare_result_pin_oe_n_o) // see [R8]
      else $error("pin driven in amplifier mode");

   // Pin driven when enabled in comparator mode
   AST_PIN_EN: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && ctrl_q[BIT_ON] && ctrl_q[BIT_PIN] && !ctrl_q[BIT_AMP] |=> !compare_result_pin_oe_n_o) // see [R2]
      else $error("pin not driven when enabled");

   // Pin carries the result one cycle later
   AST_PIN_FOLLOW: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && ctrl_q[BIT_ON] && ctrl_q[BIT_PIN] && !ctrl_q[BIT_AMP] |=> compare_result_pin_o == $past(result_q)) // see [R2]
      else $error("pin value wrong");

   // Polarity applied to the synchronised level
   AST_INVERT: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && ctrl_q[BIT_ON] && !ctrl_q[BIT_AMP] |=> result_q == ($past(sync2_q) ^ $past(ctrl_q[BIT_INV]))) // see [R3]
      else $error("result polarity wrong");

   // Result bit reads back the registered result
   AST_RESULT_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && req && adr_i == ADDR_CTRL |=> dat_o[BIT_RES] == $past(result_q)) // see [R6]
      else $error("result readback wrong");

   // Result held low while the block is off
   AST_ON_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !ctrl_q[BIT_ON] |=> !result_q) // see [R1]
      else $error("enable not honoured");

   // No comparator result in amplifier mode
   AST_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && amplifier_select_o |=> !result_q) // see [R4]
      else $error("comparator active in amplifier mode");

   // Checks on the trip flag and interrupt

   // Set flag held, no new interrupt while set
   AST_TRIP_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      trip_q && !(wr && adr_i == ADDR_CTRL) |=> trip_q && !$rose(stat_q)) // see [R5]
      else $error("trip flag dropped");

   // Interrupt status cannot rise while flag set
   AST_STAT_BLOCKED: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && trip_q |=> !$rose(stat_q)) // see [R5]
      else $error("interrupt raised while blocked");

   // Matching edge while armed sets flag and status
   AST_TRIP_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && hit && !trip_q |=> trip_q && stat_q) // see [R5]
      else $error("trip not recorded");

   // Writing zero to the flag clears it
   AST_TRIP_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr && adr_i == ADDR_CTRL && hi_lane && !dat_i[BIT_TRIP] && !trip_evt |=> !trip_q) // see [R9]
      else $error("trip flag not cleared");

   // Writing one to status clears it
   AST_STAT_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr && adr_i == ADDR_IRQ_STAT && lo_lane && dat_i[0] && !trip_evt |=> !stat_q)
      else $error("status not cleared");

   // Mask takes the written bit
   AST_MASK_WR: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr && adr_i == ADDR_IRQ_MASK && lo_lane |=> mask_q == $past(dat_i[0]))
      else $error("mask write lost");

   // Checks on registers and the bus

   // Low byte keeps only writable bits
   AST_CTRL_WR_LO: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr && adr_i == ADDR_CTRL && lo_lane |=> ctrl_q[7:0] == ($past(dat_i[7:0]) & CTRL_WMASK[7:0])) // see [R7]
      else $error("low byte write wrong");

   // High byte keeps only writable bits
   AST_CTRL_WR_HI: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr && adr_i == ADDR_CTRL && hi_lane |=> ctrl_q[15:8] == ($past(dat_i[15:8]) & CTRL_WMASK[15:8])) // see [R7]
      else $error("high byte write wrong");

   // Unused read bits 31:16 and 12:11 stay zero
   AST_UNUSED: assert property (@(posedge clk_i) disable iff (rst_i)
      dat_o[31:16] == 16'h0000 && dat_o[12:11] == 2'h0) // see [R7]
      else $error("unused bits nonzero");

   // Unmapped places read zero
   AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && req && adr_i != ADDR_CTRL && adr_i != ADDR_IRQ_STAT && adr_i != ADDR_IRQ_MASK |=> dat_o == WORD_ZERO)
      else $error("unmapped read nonzero");

   // Read data holds between requests
   AST_DAT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !req |=> $stable(dat_o))
      else $error("read data changed");

   // Taken request answered in the next cycle
   AST_ACK_AFTER_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && req |=> ack_o)
      else $error("request not answered");

   // No answer without a request
   AST_NO_ACK_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !ack_o && !req |=> !ack_o)
      else $error("ack without request");

   // Ack lasts one running cycle
   AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && ack_o |=> !ack_o)
      else $error("ack longer than one cycle");

   // Low clock enable freezes register state
   AST_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(ctrl_q) && $stable(trip_q) && $stable(stat_q) && $stable(mask_q))
      else $error("state changed while frozen");

   // Main scenarios reached
   COV_TRIP: cover property (@(posedge clk_i) disable iff (rst_i) trip_evt);
   COV_IRQ: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
   COV_PIN: cover property (@(posedge clk_i) disable iff (rst_i) !compare_result_pin_oe_n_o && compare_result_pin_o);
   COV_AMP: cover property (@(posedge clk_i) disable iff (rst_i) ce_i && amplifier_select_o);
   COV_READ: cover property (@(posedge clk_i) disable iff (rst_i) ack_o && !we_i);
endmodule

// [hdl/edge_detect.sv]
`timescale 1ns/100ps
module edge_detect (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   // Level and edge selection
   input  wire logic       level_i,
   input  wire logic [1:0] sel_i,
   // Matching edge pulse
   output logic            hit_o
);
   import cmp_ctrl_pkg::*;
   logic prev_q;
   logic rise;
   logic fall;

   // Previous level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 1'b0;
      end else if (ce_i) begin
         prev_q <= level_i;
      end
   end

   // Edge selection
   assign rise = level_i & ~prev_q;
   assign fall = ~level_i & prev_q;
   always_comb begin
      case (sel_i)
         EDGE_RISE: hit_o = rise;
         EDGE_FALL: hit_o = fall;
         EDGE_BOTH: hit_o = rise | fall;
         default:   hit_o = 1'b0;
      endcase
   end
endmodule

// [verif/comparator_control_test.sv]
`timescale 1ns/100ps
module comparator_control_test;
   import cmp_ctrl_pkg::*;
   logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, cmp_raw_i;
   logic [3:0]  adr_i, sel_i;
   logic [31:0] dat_i, dat_o;
   logic        ack_o, on_o, amp_o, ref_o, pin_o, oe_n_o, irq_o;
   logic [1:0]  chan_o;
   logic [31:0] exp_q[$];
   int          error_cnt, cmp_count, cyc_cnt;
   logic [15:0] c;
   logic        r;
   comparator_control comparator_control_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .cmp_raw_i(cmp_raw_i), .analog_block_on_o(on_o),
      .amplifier_select_o(amp_o), .ref_select_o(ref_o), .input_select_o(chan_o),
      .compare_result_pin_o(pin_o), .compare_result_pin_oe_n_o(oe_n_o), .irq_o(irq_o));
   // Clock generation
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Verdict and end of run
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // One classic Wishbone cycle; reads leave their expected data in the queue
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= {16'($urandom), d[15:0]};
      if (!w) exp_q.push_back(d);
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   // Change the analog input and let it settle to the pin
   task automatic raw(input logic v);
      @(posedge clk_i);
      cmp_raw_i <= v;
      repeat (6) @(posedge clk_i);
   endtask
   // Read data watcher: oldest note against the answer
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && cyc_i && !we_i && exp_q.size() > 0) chk(dat_o, exp_q.pop_front());
   end
   // Hang guard
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      {rst_i, ce_i, cyc_i, stb_i, we_i, cmp_raw_i} = 6'b110000;
      adr_i = 4'h0;
      sel_i = 4'hF;
      dat_i = 32'h0;
      void'($urandom(50729));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values and unmapped place
      chk({on_o, amp_o, pin_o, oe_n_o, irq_o}, 32'h2);
      bus(1'b0, ADDR_CTRL, 32'h0);
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      bus(1'b0, ADDR_IRQ_MASK, 32'h0);
      bus(1'b0, 4'hC, 32'h0);
      $display("reset test done");
      // Random control words with the block off
      for (int k = 0; k < 6; k++) begin
         c = 16'($urandom) & 16'h7FFF;
         bus(1'b1, ADDR_CTRL, {16'h0, c});
         bus(1'b0, ADDR_CTRL, {16'h0, c & CTRL_WMASK});
         chk({on_o, amp_o, ref_o, chan_o}, {1'b0, c[10], c[4], c[1:0]});
      end
      $display("register test done");
      // Polarity and pin drive
      for (int k = 0; k < 4; k++) begin
         c = 16'hC000 | {2'h0, k[0], 13'h0};
         bus(1'b1, ADDR_CTRL, {16'h0, c});
         raw(k[1]);
         r = k[1] ^ k[0];
         bus(1'b0, ADDR_CTRL, {16'h0, c | {7'h0, r, 8'h0}});
         chk({on_o, pin_o, oe_n_o}, {1'b1, r, 1'b0});
      end
      bus(1'b1, ADDR_CTRL, 32'hC400);
      repeat (6) @(posedge clk_i);
      bus(1'b0, ADDR_CTRL, 32'hC400);
      chk({amp_o, pin_o, oe_n_o}, 32'h5);
      bus(1'b1, ADDR_CTRL, 32'h8000);
      raw(1'b1);
      chk({pin_o, oe_n_o}, 32'h1);
      // Clock enable low freezes the pin path
      bus(1'b1, ADDR_CTRL, 32'hC000);
      repeat (2) @(posedge clk_i);
      chk({pin_o, oe_n_o}, 32'h2);
      ce_i <= 1'b0;
      raw(1'b0);
      chk({pin_o, oe_n_o}, 32'h2);
      ce_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk({pin_o, oe_n_o}, 32'h0);
      bus(1'b1, ADDR_CTRL, 32'h0);
      raw(1'b0);
      $display("output test done");
      // Every event polarity code
      for (int e = 0; e < 4; e++) begin
         c = 16'h8000 | {8'h0, e[1:0], 6'h0};
         bus(1'b1, ADDR_CTRL, {16'h0, c});
         raw(1'b1);
         bus(1'b0, ADDR_CTRL, {16'h0, c | {6'h0, e[0], 9'h100}});
         raw(1'b0);
         bus(1'b0, ADDR_CTRL, {16'h0, c | {6'h0, e[0] | e[1], 9'h0}});
      end
      $display("event test done");
      // Interrupt: mask, clear, blocking and rearm
      @(posedge clk_i);
      chk(irq_o, 32'h0);
      bus(1'b1, ADDR_IRQ_MASK, 32'h1);
      @(posedge clk_i);
      chk(irq_o, 32'h1);
      bus(1'b0, ADDR_IRQ_STAT, 32'h1);
      bus(1'b1, ADDR_IRQ_STAT, 32'h1);
      raw(1'b1);
      raw(1'b0);
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk(irq_o, 32'h0);
      bus(1'b1, ADDR_CTRL, {16'h0, c});
      raw(1'b1);
      bus(1'b0, ADDR_CTRL, {16'h0, c | 16'h0300});
      bus(1'b0, ADDR_IRQ_STAT, 32'h1);
      chk(irq_o, 32'h1);
      bus(1'b1, ADDR_IRQ_MASK, 32'h0);
      @(posedge clk_i);
      chk(irq_o, 32'h0);
      $display("interrupt test done");
      end_of_test();
   end
endmodule
